// ### icu_defs.svh
// constants of the serial bus control block: offsets, field positions, resets, address bytes
// assumes inclusion by bare name from the package and modules
`ifndef ICU_DEFS_SVH
`define ICU_DEFS_SVH

// register byte offsets on the APB side
`define ICU_CTRL_OFF      12'h000
`define ICU_ADDR_OFF      12'h004
`define ICU_STAT_OFF      12'h008

// bus_control_word field positions
`define ICU_PORT_ON       15
`define ICU_HALT_IDLE     13
`define ICU_CLK_REL       12
`define ICU_ACCEPT_ALL    11
`define ICU_LONG_ADDR     10
`define ICU_SLEW_OFF      9
`define ICU_SMB_THR       8
`define ICU_BCAST_ON      7
`define ICU_STRETCH       6

// reset values and writable mask
`define ICU_CTRL_RST      16'h1000
`define ICU_CTRL_WMASK    16'hBFC0
`define ICU_ADDR_RST      10'h000

// status field positions
`define ICU_ST_BUSY       0
`define ICU_ST_ADDRESSED  1
`define ICU_ST_TX         2
`define ICU_ST_HELD       3
`define ICU_ST_ACTIVE     4
`define ICU_ST_BCAST      5

// address byte constants
`define ICU_HDR10         5'h1E
`define ICU_BCAST_ADDR    8'h00
`define ICU_BYTE_BITS     4'h8

`endif

// ### icu_pkg.sv
// types shared by the serial bus control block
// assumes icu_defs.svh on the include path
package icu_pkg;
`include "icu_defs.svh"

  typedef enum logic [5:0] {
    ICU_IDLE  = 6'h01,
    ICU_ADDR  = 6'h02,
    ICU_ADDR2 = 6'h04,
    ICU_ACK   = 6'h08,
    ICU_DATA  = 6'h10,
    ICU_TX    = 6'h20
  } icu_state_t;

  typedef logic [15:0] icu_word_t;
endpackage : icu_pkg

// ### icu_link_if.sv
// carrier between the control register block and its bus watcher
// assumes both ends run on pclk
`timescale 1ns/1ps
interface icu_link_if;
  logic       scl_raw;
  logic       sda_raw;
  logic       enable;
  logic       accept_all;
  logic       long_addr;
  logic       bcast_on;
  logic [9:0] own_addr;
  logic       scl_level;
  logic       busy;
  logic       addressed;
  logic       transmitting;
  logic       ack_drive;
  logic       tx_begin;
  logic       rx_end;
  logic       bcast_hit;

  modport ctl (output scl_raw, sda_raw, enable, accept_all, long_addr, bcast_on, own_addr,
               input scl_level, busy, addressed, transmitting, ack_drive, tx_begin, rx_end,
               bcast_hit);
  modport mon (input scl_raw, sda_raw, enable, accept_all, long_addr, bcast_on, own_addr,
               output scl_level, busy, addressed, transmitting, ack_drive, tx_begin, rx_end,
               bcast_hit);
endinterface : icu_link_if

// ### icu_bus_watch.sv
// slave side bus watcher: pin synchronisers, start/stop, address match, acknowledge
// assumes raw pin levels from another domain; sampled at 8x the bus clock or faster
`timescale 1ns/1ps
`include "icu_defs.svh"
module icu_bus_watch
  import icu_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  icu_link_if.mon  lk
);
  import icu_pkg::*;

  logic [1:0] scl_sync_reg;
  logic [1:0] sda_sync_reg;
  logic       scl_d_reg;
  logic       sda_d_reg;
  icu_state_t state_reg, state_next;
  logic [7:0] shift_reg, shift_next;
  logic [3:0] cnt_reg, cnt_next;
  logic       rd_reg, rd_next;
  logic       second_reg, second_next;
  logic       hdr10_reg, hdr10_next;
  logic       ack_reg, ack_next;
  logic       txb_reg, txb_next;
  logic       rxe_reg, rxe_next;
  logic       gc_reg, gc_next;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scl_sync_reg <= 2'h3;
      sda_sync_reg <= 2'h3;
      scl_d_reg    <= 1'b1;
      sda_d_reg    <= 1'b1;
    end else begin
      scl_sync_reg <= {scl_sync_reg[0], lk.scl_raw};
      sda_sync_reg <= {sda_sync_reg[0], lk.sda_raw};
      scl_d_reg    <= scl_sync_reg[1];
      sda_d_reg    <= sda_sync_reg[1];
    end
  end

  wire scl_s      = scl_sync_reg[1];
  wire sda_s      = sda_sync_reg[1];
  wire scl_rise   = scl_s & ~scl_d_reg;
  wire scl_fall   = ~scl_s & scl_d_reg;
  wire start_cond = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
  wire stop_cond  = scl_s & scl_d_reg & ~sda_d_reg & sda_s;
  wire byte_done  = (cnt_reg == `ICU_BYTE_BITS);
  wire gc_match   = lk.bcast_on && (shift_reg == `ICU_BCAST_ADDR);
  wire hdr_match  = (shift_reg[7:3] == `ICU_HDR10) && (shift_reg[2:1] == lk.own_addr[9:8]);
  wire a7_match   = (shift_reg[7:1] == lk.own_addr[6:0]);
  // without accept-all, a long read header is only honoured after a full long address match
  wire long_ok    = hdr_match & (~shift_reg[0] | hdr10_reg);
  wire first_ack  = lk.accept_all | gc_match | (lk.long_addr ? long_ok : a7_match);
  wire need_2nd   = lk.long_addr & ~lk.accept_all & ~gc_match & ~shift_reg[0];
  wire second_ack = lk.accept_all | (shift_reg == lk.own_addr[7:0]);

  always_comb begin
    state_next  = state_reg;
    shift_next  = shift_reg;
    cnt_next    = cnt_reg;
    rd_next     = rd_reg;
    second_next = second_reg;
    hdr10_next  = hdr10_reg;
    ack_next    = ack_reg;
    txb_next    = 1'b0;
    rxe_next    = 1'b0;
    gc_next     = 1'b0;
    if (!lk.enable || stop_cond) begin
      state_next = ICU_IDLE;
      ack_next   = 1'b0;
      hdr10_next = 1'b0;
    end else if (start_cond) begin
      state_next = ICU_ADDR;
      cnt_next   = 4'h0;
      ack_next   = 1'b0;
    end else if (scl_rise && !byte_done &&
                 (state_reg == ICU_ADDR || state_reg == ICU_ADDR2 || state_reg == ICU_DATA)) begin
      shift_next = {shift_reg[6:0], sda_s};
      cnt_next   = cnt_reg + 4'h1;
    end else if (scl_fall) begin
      case (state_reg)
        ICU_ADDR: if (byte_done) begin
          state_next  = first_ack ? ICU_ACK : ICU_IDLE;
          ack_next    = first_ack;
          rd_next     = shift_reg[0] & ~gc_match;
          second_next = need_2nd;
          gc_next     = first_ack & gc_match;
        end
        ICU_ADDR2: if (byte_done) begin
          state_next  = second_ack ? ICU_ACK : ICU_IDLE;
          ack_next    = second_ack;
          hdr10_next  = second_ack;
          second_next = 1'b0;
          rd_next     = 1'b0;
        end
        ICU_DATA: if (byte_done) begin
          state_next = ICU_ACK;
          ack_next   = 1'b1;
          rxe_next   = 1'b1;
        end
        ICU_ACK: begin
          ack_next = 1'b0;
          cnt_next = 4'h0;
          if (second_reg) begin
            state_next = ICU_ADDR2;
          end else if (rd_reg) begin
            state_next = ICU_TX;
            txb_next   = 1'b1;
          end else begin
            state_next = ICU_DATA;
          end
        end
        ICU_IDLE, ICU_TX: state_next = state_reg;
        default: state_next = ICU_IDLE;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg  <= ICU_IDLE;
      shift_reg  <= 8'h00;
      cnt_reg    <= 4'h0;
      rd_reg     <= 1'b0;
      second_reg <= 1'b0;
      hdr10_reg  <= 1'b0;
      ack_reg    <= 1'b0;
      txb_reg    <= 1'b0;
      rxe_reg    <= 1'b0;
      gc_reg     <= 1'b0;
    end else begin
      state_reg  <= state_next;
      shift_reg  <= shift_next;
      cnt_reg    <= cnt_next;
      rd_reg     <= rd_next;
      second_reg <= second_next;
      hdr10_reg  <= hdr10_next;
      ack_reg    <= ack_next;
      txb_reg    <= txb_next;
      rxe_reg    <= rxe_next;
      gc_reg     <= gc_next;
    end
  end

  assign lk.scl_level    = scl_s;
  assign lk.busy         = (state_reg != ICU_IDLE);
  assign lk.addressed    = (state_reg == ICU_ACK) || (state_reg == ICU_DATA) ||
                           (state_reg == ICU_TX) || (state_reg == ICU_ADDR2);
  assign lk.transmitting = (state_reg == ICU_TX);
  assign lk.ack_drive    = ack_reg;
  assign lk.tx_begin     = txb_reg;
  assign lk.rx_end       = rxe_reg;
  assign lk.bcast_hit    = gc_reg;
endmodule : icu_bus_watch

// ### icu_ctrl.sv
// serial bus port control: APB register file, clock release and stretch, pin ownership
// assumes APB master on pclk; pins are open drain, resolved outside; idle request on pclk
// Overview of operation
// - as slave, release the clock line when release is 1, hold it low when 0
// - without stretch, software only sets release; hardware clears it on slave transmit start
// - accept-all set acknowledges every address; clear uses normal address matching
// - slew-limit-off set disables pin slew-rate control; clear keeps it enabled
// - smbus threshold set selects SMBus input levels; clear keeps standard levels
`timescale 1ns/1ps
`include "icu_defs.svh"
module icu_ctrl
  import icu_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        cpu_idle,
  input  wire logic        serial_clock_pin_in,
  output logic             serial_clock_pin_out,
  output logic             serial_clock_pin_oe,
  input  wire logic        serial_data_pin_in,
  output logic             serial_data_pin_out,
  output logic             serial_data_pin_oe,
  input  wire logic        port_clock_out,
  input  wire logic        port_clock_oe,
  input  wire logic        port_data_out,
  input  wire logic        port_data_oe,
  output logic             pins_owned,
  output logic             slew_limit_off,
  output logic             smbus_threshold_sel
);
  import icu_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // register state

  icu_word_t   ctrl_reg, ctrl_next;
  logic [9:0]  addr_reg, addr_next;
  logic        bcast_seen_reg, bcast_seen_next;
  logic        hold_reg, hold_next;
  logic        pready_reg;
  logic        pslverr_reg;
  logic [31:0] prdata_reg;
  logic        scl_out_reg, scl_oe_reg;
  logic        sda_out_reg, sda_oe_reg;
  logic        owned_reg;
  logic        slew_reg;
  logic        smb_reg;

  icu_link_if lk ();

  ////////////////////////////////////////////////////////////////////////////////
  // control fields

  wire port_on               = ctrl_reg[`ICU_PORT_ON];
  wire halt_when_idle        = ctrl_reg[`ICU_HALT_IDLE];
  wire clock_line_release    = ctrl_reg[`ICU_CLK_REL];
  wire management_accept_all = ctrl_reg[`ICU_ACCEPT_ALL];
  wire long_slave_address_sel = ctrl_reg[`ICU_LONG_ADDR];
  wire slew_off_bit          = ctrl_reg[`ICU_SLEW_OFF];
  wire smb_bit               = ctrl_reg[`ICU_SMB_THR];
  wire broadcast_call_irq_on = ctrl_reg[`ICU_BCAST_ON];
  wire stretch_allow         = ctrl_reg[`ICU_STRETCH];

  // idle with halt set behaves as switched off, but pins stay owned
  wire running = port_on & ~(halt_when_idle & cpu_idle);

  ////////////////////////////////////////////////////////////////////////////////
  // bus watcher

  assign lk.scl_raw    = serial_clock_pin_in;
  assign lk.sda_raw    = serial_data_pin_in;
  assign lk.enable     = running;
  assign lk.accept_all = management_accept_all;
  assign lk.long_addr  = long_slave_address_sel;
  assign lk.bcast_on   = broadcast_call_irq_on;
  assign lk.own_addr   = addr_reg;

  icu_bus_watch u_watch (
    .pclk    (pclk),
    .presetn (presetn),
    .lk      (lk.mon)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // APB decode

  function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
    hit = (a[11:2] == off[11:2]);
  endfunction : hit

  wire hit_ctrl  = hit(paddr, `ICU_CTRL_OFF);
  wire hit_addr  = hit(paddr, `ICU_ADDR_OFF);
  wire hit_stat  = hit(paddr, `ICU_STAT_OFF);
  wire mapped    = hit_ctrl | hit_addr | hit_stat;
  // one wait state: pready is a flop, so the access phase lasts two cycles
  wire access    = psel & penable & ~pready_reg;
  wire commit    = psel & penable & pready_reg;
  wire wr_commit = commit & pwrite & mapped;
  wire lo_lane   = pstrb[0];
  wire hi_lane   = pstrb[1];

  wire [15:0] lane_mask = {{8{hi_lane}}, {8{lo_lane}}} & `ICU_CTRL_WMASK;
  wire [15:0] ctrl_wval = (ctrl_reg & ~lane_mask) | (pwdata[15:0] & lane_mask);

  ////////////////////////////////////////////////////////////////////////////////
  // status and read data

  wire [5:0] status_bits = {bcast_seen_reg, running, hold_reg, lk.transmitting,
                            lk.addressed, lk.busy};

  wire [31:0] rd_value = hit_ctrl ? {16'h0000, ctrl_reg} :
                         hit_addr ? {22'h000000, addr_reg} :
                         hit_stat ? {26'h0000000, status_bits} :
                                    32'h00000000;

  ////////////////////////////////////////////////////////////////////////////////
  // next values

  // release may be cleared by hardware while software writes; hardware clear wins
  wire rel_hw_clear = lk.tx_begin | (stretch_allow & lk.rx_end);
  // without stretch a write of 0 to release leaves it unchanged
  wire rel_sw_value = (stretch_allow | ctrl_wval[`ICU_CLK_REL]) ?
                      ctrl_wval[`ICU_CLK_REL] : clock_line_release;

  always_comb begin
    ctrl_next = ctrl_reg;
    if (wr_commit && hit_ctrl) begin
      ctrl_next                = ctrl_wval;
      ctrl_next[`ICU_CLK_REL]  = rel_sw_value;
    end
    if (rel_hw_clear) begin
      ctrl_next[`ICU_CLK_REL]  = 1'b0;
    end
  end

  always_comb begin
    addr_next = addr_reg;
    if (wr_commit && hit_addr) begin
      if (lo_lane) begin
        addr_next[7:0] = pwdata[7:0];
      end
      if (hi_lane) begin
        addr_next[9:8] = pwdata[9:8];
      end
    end
  end

  // write one clears; a new hit in the same cycle keeps the flag
  always_comb begin
    bcast_seen_next = bcast_seen_reg;
    if (wr_commit && hit_stat && lo_lane && pwdata[`ICU_ST_BCAST]) begin
      bcast_seen_next = 1'b0;
    end
    if (lk.bcast_hit) begin
      bcast_seen_next = 1'b1;
    end
  end

  // stretch starts only while the clock is already low, never cutting a high phase
  always_comb begin
    hold_next = running & lk.addressed & ~clock_line_release &
                (hold_reg | ~lk.scl_level);
  end

  ////////////////////////////////////////////////////////////////////////////////
  // pin ownership; open drain, so the serial side only ever drives low

  wire scl_oe_next  = port_on ? hold_reg : port_clock_oe;
  wire scl_out_next = port_on ? 1'b0 : port_clock_out;
  wire sda_oe_next  = port_on ? (running & lk.ack_drive) : port_data_oe;
  wire sda_out_next = port_on ? 1'b0 : port_data_out;

  ////////////////////////////////////////////////////////////////////////////////
  // flops

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg       <= `ICU_CTRL_RST;
      addr_reg       <= `ICU_ADDR_RST;
      bcast_seen_reg <= 1'b0;
      hold_reg       <= 1'b0;
    end else begin
      ctrl_reg       <= ctrl_next;
      addr_reg       <= addr_next;
      bcast_seen_reg <= bcast_seen_next;
      hold_reg       <= hold_next;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= 32'h00000000;
    end else begin
      pready_reg  <= access;
      pslverr_reg <= access & ~mapped;
      prdata_reg  <= (access & ~pwrite) ? rd_value : 32'h00000000;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scl_out_reg <= 1'b0;
      scl_oe_reg  <= 1'b0;
      sda_out_reg <= 1'b0;
      sda_oe_reg  <= 1'b0;
      owned_reg   <= 1'b0;
    end else begin
      scl_out_reg <= scl_out_next;
      scl_oe_reg  <= scl_oe_next;
      sda_out_reg <= sda_out_next;
      sda_oe_reg  <= sda_oe_next;
      owned_reg   <= port_on;
    end
  end

  // pad controls follow the register one cycle later
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      slew_reg <= 1'b0;
      smb_reg  <= 1'b0;
    end else begin
      slew_reg <= slew_off_bit;
      smb_reg  <= smb_bit;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // outputs

  assign prdata               = prdata_reg;
  assign pready               = pready_reg;
  assign pslverr              = pslverr_reg;
  assign serial_clock_pin_out = scl_out_reg;
  assign serial_clock_pin_oe  = scl_oe_reg;
  assign serial_data_pin_out  = sda_out_reg;
  assign serial_data_pin_oe   = sda_oe_reg;
  assign pins_owned           = owned_reg;
  assign slew_limit_off       = slew_reg;
  assign smbus_threshold_sel  = smb_reg;
endmodule : icu_ctrl

// ### icu_ctrl_checker.sv
// port checker for icu_ctrl
// assumes bind onto icu_ctrl, one clock domain
`timescale 1ns/1ps
module icu_ctrl_checker (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        cpu_idle,
  input wire logic        serial_clock_pin_out,
  input wire logic        serial_clock_pin_oe,
  input wire logic        serial_data_pin_out,
  input wire logic        serial_data_pin_oe,
  input wire logic        port_clock_out,
  input wire logic        port_clock_oe,
  input wire logic        port_data_out,
  input wire logic        port_data_oe,
  input wire logic        pins_owned,
  input wire logic        slew_limit_off,
  input wire logic        smbus_threshold_sel
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire ctrl_wr = psel && penable && pready && pwrite && paddr[11:2] == 10'h000 && pstrb[1];
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_wait;
    psel && penable && !pready;
  endsequence
  ////////////////
  a_apb_first: assert property (s_setup |=> s_wait) else $error("pready too early");
  a_apb_wait: assert property (s_setup ##1 s_wait |=> pready) else $error("pready late");
  a_ready_pulse: assert property (pready |=> !pready) else $error("pready held");
  a_err_pair: assert property (pslverr |-> pready) else $error("pslverr alone");
  a_rdata_zero: assert property (!pready |-> prdata == 32'h0) else $error("prdata not 0");
  a_slew_copy: assert property (ctrl_wr |=> ##1 slew_limit_off == $past(pwdata[9], 2))
    else $error("slew output wrong");
  a_smb_copy: assert property (ctrl_wr |=> ##1 smbus_threshold_sel == $past(pwdata[8], 2))
    else $error("threshold output wrong");
  a_owned_copy: assert property (ctrl_wr |=> ##1 pins_owned == $past(pwdata[15], 2))
    else $error("ownership wrong");
  a_port_pins: assert property (!pins_owned && $past(presetn) |->
    {serial_clock_pin_out, serial_clock_pin_oe, serial_data_pin_out, serial_data_pin_oe} ==
    $past({port_clock_out, port_clock_oe, port_data_out, port_data_oe})) else $error("port pins");
  a_owned_quiet: assert property (pins_owned |->
    !serial_clock_pin_out && !serial_data_pin_out) else $error("owned pin driven high");
  a_release_drop: assert property (ctrl_wr && pwdata[12] && pwdata[15] && pins_owned
    |=> ##[1:2] !serial_clock_pin_oe) else $error("clock not released");
  // a hold may only end through a register write or idle halt
  a_hold_stays: assert property (pins_owned && serial_clock_pin_oe && !cpu_idle && !psel
    && !$past(psel) && !$past(psel, 2) |=> serial_clock_pin_oe) else $error("hold dropped");
endmodule : icu_ctrl_checker

bind icu_ctrl icu_ctrl_checker u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .cpu_idle(cpu_idle),
  .serial_clock_pin_out(serial_clock_pin_out), .serial_clock_pin_oe(serial_clock_pin_oe),
  .serial_data_pin_out(serial_data_pin_out), .serial_data_pin_oe(serial_data_pin_oe),
  .port_clock_out(port_clock_out), .port_clock_oe(port_clock_oe),
  .port_data_out(port_data_out), .port_data_oe(port_data_oe), .pins_owned(pins_owned),
  .slew_limit_off(slew_limit_off), .smbus_threshold_sel(smbus_threshold_sel));

// ### icu_ext_master.sv
// far-side bus master on the two-wire bus
// assumes pull-ups on both lines; the port pulls low through its enables
`timescale 1ns/1ps
module icu_ext_master (
  input  wire logic pclk,
  input  wire logic scl_oe,
  input  wire logic sda_oe,
  output logic      scl_wire,
  output logic      sda_wire
);
  logic m_scl = 1'b1;
  logic m_sda = 1'b1;
  int   stuck = 0;
  assign scl_wire = m_scl & ~scl_oe;
  assign sda_wire = m_sda & ~sda_oe;
  // clock high phase; waits out a stretch, bounded so a stuck hold cannot hang the run
  task automatic rise;
    int n;
    m_scl <= 1'b1;
    n = 0;
    repeat (4) @(posedge pclk);
    while (!scl_wire && n < 5000) begin
      @(posedge pclk);
      n++;
    end
    if (n == 5000) stuck++;
  endtask : rise
  task automatic start;
    @(posedge pclk);
    m_sda <= 1'b0;
    repeat (4) @(posedge pclk);
    m_scl <= 1'b0;
  endtask : start
  // data moves one cycle after the fall, never with the clock high
  task automatic slot(input logic v, output logic seen);
    @(posedge pclk);
    m_sda <= v;
    repeat (3) @(posedge pclk);
    rise();
    seen = sda_wire;
    m_scl <= 1'b0;
  endtask : slot
  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) slot(b[i], s);
    slot(1'b1, s);
    ack = ~s;
  endtask : send_byte
  task automatic stop;
    @(posedge pclk);
    m_sda <= 1'b0;
    repeat (3) @(posedge pclk);
    rise();
    m_sda <= 1'b1;
    repeat (8) @(posedge pclk);
  endtask : stop
endmodule : icu_ext_master

// ### testbench.sv
// testbench for icu_ctrl: register file, port pins, address match, stretching
// assumes icu_ext_master as the far-side bus master
`timescale 1ns/1ps
`include "icu_defs.svh"
module testbench;
  import icu_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, cpu_idle, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0]  pstrb;
  logic        scl_in, sda_in, scl_out, scl_oe, sda_out, sda_oe, ack;
  logic        pc_out, pc_oe, pd_out, pd_oe, owned, slew, smb;
  logic [32:0] exp_q[$];
  int          failures, checks_done, seed;
  icu_word_t   ctl;
  logic [6:0]  own;

  icu_ctrl dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .cpu_idle(cpu_idle), .serial_clock_pin_in(scl_in),
    .serial_clock_pin_out(scl_out), .serial_clock_pin_oe(scl_oe),
    .serial_data_pin_in(sda_in), .serial_data_pin_out(sda_out), .serial_data_pin_oe(sda_oe),
    .port_clock_out(pc_out), .port_clock_oe(pc_oe), .port_data_out(pd_out),
    .port_data_oe(pd_oe), .pins_owned(owned), .slew_limit_off(slew),
    .smbus_threshold_sel(smb));
  icu_ext_master pm (.pclk(pclk), .scl_oe(scl_oe), .sda_oe(sda_oe), .scl_wire(scl_in),
    .sda_wire(sda_in));

  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  ////////////////
  task automatic chk(input string nm, input logic [32:0] seen, input logic [32:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic report_and_stop;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : report_and_stop
  // e is {pslverr, prdata} expected when pready comes
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      input logic [32:0] e);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    exp_q.push_back(e);
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      failures++;
      report_and_stop();
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : xfer
  task automatic addr_try(input logic [7:0] b, input logic e);
    pm.start();
    pm.send_byte(b, ack);
    pm.stop();
    chk("ack", ack, e);
  endtask : addr_try
  // second process: every finished transfer takes the oldest note
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1) begin
      if (exp_q.size() == 0) chk("queue", 1'b1, 1'b0);
      else chk("apb", {pslverr, prdata}, exp_q.pop_front());
    end
  end
  ////////////////
  initial begin
    {psel, penable, pwrite, cpu_idle, pc_out, pc_oe, pd_out, pd_oe} = 8'h00;
    {paddr, pwdata, pstrb} = {12'h000, 32'h0, 4'hF};
    {failures, checks_done, seed, presetn} = {32'd0, 32'd0, 32'd50, 1'b0};
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    xfer(1'b0, `ICU_CTRL_OFF, 32'h0, {17'h0, `ICU_CTRL_RST});
    xfer(1'b0, `ICU_ADDR_OFF, 32'h0, 33'h0);
    xfer(1'b0, 12'h00C, 32'h0, 33'h1_0000_0000);
    xfer(1'b1, 12'h010, 32'hFFFF, 33'h1_0000_0000);
    xfer(1'b0, `ICU_CTRL_OFF, 32'h0, {17'h0, `ICU_CTRL_RST});
    $display("test reset done");
    for (int i = 0; i < 6; i++) begin
      ctl = 16'($random(seed)) | 16'h9000;
      xfer(1'b1, `ICU_CTRL_OFF, {16'h0, ctl}, 33'h0);
      xfer(1'b0, `ICU_CTRL_OFF, 32'h0, {17'h0, ctl & `ICU_CTRL_WMASK});
      chk("slew", slew, ctl[9]);
      chk("smbus", smb, ctl[8]);
      chk("owned", owned, 1'b1);
    end
    // stretch off first, so the later write of 0 to release must be ignored
    xfer(1'b1, `ICU_CTRL_OFF, 32'h9000, 33'h0);
    xfer(1'b1, `ICU_CTRL_OFF, 32'h8000, 33'h0);
    xfer(1'b0, `ICU_CTRL_OFF, 32'h0, 33'h9000);
    $display("test control done");
    xfer(1'b1, `ICU_CTRL_OFF, 32'h1000, 33'h0);
    for (int i = 0; i < 8; i++) begin
      {pc_out, pc_oe, pd_out, pd_oe} <= 4'($random(seed));
      repeat (2) @(posedge pclk);
      chk("pins", {scl_out, scl_oe, sda_out, sda_oe}, {pc_out, pc_oe, pd_out, pd_oe});
      chk("owned", owned, 1'b0);
    end
    {pc_out, pc_oe, pd_out, pd_oe} <= 4'h0;
    $display("test port done");
    own = 7'($random(seed));
    xfer(1'b1, `ICU_ADDR_OFF, {25'h0, own}, 33'h0);
    xfer(1'b1, `ICU_CTRL_OFF, 32'h9000, 33'h0);
    addr_try({own ^ 7'h01, 1'b0}, 1'b0);
    addr_try({own, 1'b0}, 1'b1);
    xfer(1'b1, `ICU_CTRL_OFF, 32'h9800, 33'h0);
    addr_try({own ^ 7'h01, 1'b0}, 1'b1);
    // long addressing: upper address bits are 0, so only that header matches
    xfer(1'b1, `ICU_CTRL_OFF, 32'h9400, 33'h0);
    addr_try({`ICU_HDR10, 3'h0}, 1'b1);
    addr_try({`ICU_HDR10, 3'h2}, 1'b0);
    xfer(1'b1, `ICU_CTRL_OFF, 32'h9000, 33'h0);
    $display("test address done");
    pm.start();
    pm.send_byte({own, 1'b1}, ack);
    chk("ack", ack, 1'b1);
    repeat (10) @(posedge pclk);
    chk("held", scl_oe, 1'b1);
    xfer(1'b0, `ICU_CTRL_OFF, 32'h0, 33'h8000);
    xfer(1'b1, `ICU_CTRL_OFF, 32'h9000, 33'h0);
    repeat (2) @(posedge pclk);
    chk("freed", scl_oe, 1'b0);
    pm.stop();
    chk("stretch wait", pm.stuck, 0);
    $display("test stretch done");
    report_and_stop();
  end
endmodule : testbench
